// *** include/decode_pkg.sv ***
// package: register map, field layout, opcodes and types of the instruction decoder
package decode_pkg;
  localparam logic [5:0]  OFS_CTRL   = 6'h00;
  localparam logic [5:0]  OFS_INSN   = 6'h04;
  localparam logic [5:0]  OFS_PC     = 6'h08;
  localparam logic [5:0]  OFS_SRCV   = 6'h0c;
  localparam logic [5:0]  OFS_TGTV   = 6'h10;
  localparam logic [5:0]  OFS_FIELDS = 6'h14;
  localparam logic [5:0]  OFS_OPND   = 6'h18;
  localparam logic [5:0]  OFS_TARGET = 6'h1c;
  localparam logic [5:0]  OFS_EADDR  = 6'h20;
  localparam logic [5:0]  OFS_STATUS = 6'h24;
  localparam int          CTRL_BIG_BIT  = 0;
  localparam int          CTRL_COMP_BIT = 1;
  localparam int          FLD_SRC_LSB   = 0;
  localparam int          FLD_TGT_LSB   = 5;
  localparam int          FLD_DST_LSB   = 10;
  localparam int          FLD_SHIFT_LSB = 15;
  localparam int          FLD_FUNC_LSB  = 20;
  localparam int          FLD_FMT_LSB   = 26;
  localparam int          FLD_TRAP_BIT  = 28;
  localparam int          STS_DERR_BIT  = 0;
  localparam int          STS_FERR_BIT  = 1;
  localparam int          STS_NULL_BIT  = 2;
  localparam int          STS_SLOT_BIT  = 3;
  localparam int          STS_TAKEN_BIT = 4;
  localparam int          STS_MEM_BIT   = 5;
  localparam int          STS_LANE_LSB  = 8;
  localparam int          STS_MUL_LSB   = 16;
  localparam int          STS_FLANE_LSB = 24;
  localparam logic [1:0]  CTRL_RST      = 2'h0;
  localparam logic [31:0] WORD_RST      = 32'h0;
  localparam logic [3:0]  LOAD_STALL_CYC = 4'h1;
  localparam logic [3:0]  MUL_LAT_CYC    = 4'h4;
  localparam logic [5:0]  OP_SPECIAL  = 6'h00;
  localparam logic [5:0]  OP_REGIMM   = 6'h01;
  localparam logic [5:0]  OP_J        = 6'h02;
  localparam logic [5:0]  OP_JAL      = 6'h03;
  localparam logic [5:0]  OP_BEQ      = 6'h04;
  localparam logic [5:0]  OP_BNE      = 6'h05;
  localparam logic [5:0]  OP_BLEZ     = 6'h06;
  localparam logic [5:0]  OP_BGTZ     = 6'h07;
  localparam logic [5:0]  OP_ANDI     = 6'h0c;
  localparam logic [5:0]  OP_XORI     = 6'h0e;
  localparam logic [5:0]  OP_COP1X    = 6'h13;
  localparam logic [5:0]  OP_SPECIAL2 = 6'h1c;
  localparam logic [2:0]  OPG_LIKELY  = 3'h2;
  localparam logic [2:0]  OPG_LOAD    = 3'h4;
  localparam logic [2:0]  OPG_STORE   = 3'h5;
  localparam logic [2:0]  OPG_LOADX   = 3'h6;
  localparam logic [2:0]  OPG_STOREX  = 3'h7;
  localparam logic [5:0]  FN_JR       = 6'h08;
  localparam logic [5:0]  FN_JALR     = 6'h09;
  localparam logic [5:0]  FN_SYSCALL  = 6'h0c;
  localparam logic [5:0]  FN_BREAK    = 6'h0d;
  localparam logic [5:0]  FN_RD_TOP   = 6'h10;
  localparam logic [5:0]  FN_RD_BOT   = 6'h12;
  localparam logic [2:0]  FNG_MULDIV  = 3'h3;
  localparam logic [2:0]  FNG_TRAP    = 3'h6;
  typedef enum logic [1:0] {FMT_IMM = 2'b00, FMT_JUMP = 2'b01, FMT_REG = 2'b10} fmt_e;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EVAL = 2'b01, ST_HOLD = 2'b10} st_e;
  typedef enum logic [2:0] {SZ_BYTE = 3'b000, SZ_HALF = 3'b001, SZ_WORD = 3'b010,
                            SZ_DBL = 3'b011, SZ_LEFT = 3'b100, SZ_RIGHT = 3'b101} sz_e;
  typedef struct packed {
    logic [5:0]  op;
    logic [4:0]  src;
    logic [4:0]  tgt;
    logic [4:0]  dst;
    logic [4:0]  shift;
    logic [5:0]  func;
    logic [15:0] imm;
    logic [25:0] jidx;
  } fields_s;
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [5:0] addr;
  } ahb_req_s;
endpackage : decode_pkg

// *** logic/insn_decode_top.sv ***
// instruction format decoder with byte-lane, target and interlock logic behind an AHB-Lite slave
// Contract
// - each instruction is one 32-bit word at a word-aligned address
// - three layouts recognised: immediate, jump, register; extraction follows layout
// - source and target/condition selector fields are 5 bits each
// - immediate layout carries 16-bit operand, branch or address displacement
// - jump layout carries a 26-bit target field
// - register layout has 5-bit destination, 5-bit shift count, 6-bit operation
// - integer load/store address is base register plus sign-extended 16-bit offset
// - float load/store also allows indexed form adding two registers
// - reading a just-loaded register stalls with interlock cycles, never stale; the code does not check the index (target) register of the indexed form
// - computed address names the low-order byte for every size and order
// - big-endian low-order byte is most significant; little-endian least
// - size plus three low address bits select lanes; bad alignment errors
// - fetches are halfwords in compressed mode, words otherwise, same byte order
// - register form takes both operands from registers, immediate form one
// - multiply runs aside; product read before ready stalls the pipeline
// - jumps and branches act after one instruction; delay slot executes
// - jump target is field shifted by two under upper 4 pc bits; the code takes them from the delay-slot address pc_q + 4
// - register jumps take full 32-bit target from the selected register
// - branch target is delay-slot address plus offset shifted two, sign-extended
// - branch-likely not taken nullifies its delay-slot instruction
// - trap-initiating control instructions always decode as register form
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module insn_decode_top
  import decode_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  output logic             o_stall,
  output logic             o_addr_err
);

  function automatic fields_s unpack(input logic [31:0] w);
    fields_s f;
    f.op    = w[31:26];
    f.src   = w[25:21];
    f.tgt   = w[20:16];
    f.dst   = w[15:11];
    f.shift = w[10:6];
    f.func  = w[5:0];
    f.imm   = w[15:0];
    f.jidx  = w[25:0];
    return f;
  endfunction : unpack

  function automatic fmt_e fmt_of(input logic [5:0] op);
    // all trap and system-call functions sit under the special opcode
    if (op == OP_SPECIAL) return FMT_REG;
    if (op == OP_J || op == OP_JAL) return FMT_JUMP;
    return FMT_IMM;
  endfunction : fmt_of

  function automatic logic is_mem(input fields_s f);
    logic cx;
    cx = (f.op == OP_COP1X) && (f.func[5:4] == 2'h0) && (f.func[2:1] == 2'h0);
    return (f.op[5:3] >= OPG_LOAD) || cx;
  endfunction : is_mem

  function automatic logic is_indexed(input fields_s f);
    return f.op == OP_COP1X;
  endfunction : is_indexed

  function automatic logic is_load(input fields_s f);
    return (f.op[5:3] == OPG_LOAD) || (f.op[5:3] == OPG_LOADX) ||
           (is_indexed(f) && !f.func[3]);
  endfunction : is_load

  function automatic sz_e size_of(input fields_s f);
    sz_e s;
    s = SZ_WORD;
    if (is_indexed(f)) begin
      s = f.func[0] ? SZ_DBL : SZ_WORD;
    end else if (f.op[5:4] == 2'h2) begin
      case (f.op[1:0])
        2'h0:    s = SZ_BYTE;
        2'h1:    s = SZ_HALF;
        2'h2:    s = f.op[2] ? SZ_RIGHT : SZ_LEFT;
        default: s = SZ_WORD;
      endcase
    end else if (f.op[2:0] >= 3'h5) begin
      s = SZ_DBL;
    end
    return s;
  endfunction : size_of

  // lanes of a doubleword, bit 0 the lowest-addressed byte in little-endian order
  function automatic logic [7:0] lanes_of(input sz_e s, input logic [2:0] a, input logic big);
    logic [7:0] m;
    logic [7:0] r;
    logic [3:0] nib;
    nib = 4'h0;
    case (s)
      SZ_BYTE:  m = 8'h01 << a;
      SZ_HALF:  m = 8'h03 << a;
      SZ_WORD:  m = 8'h0f << a;
      SZ_DBL:   m = 8'hff;
      SZ_LEFT: begin
        nib = 4'((5'h02 << a[1:0]) - 5'h01);
        m = {4'h0, nib} << {a[2], 2'b00};
      end
      SZ_RIGHT: begin
        nib = 4'((5'h0f << a[1:0]) & 5'h0f);
        m = {4'h0, nib} << {a[2], 2'b00};
      end
      default:  m = 8'h00;
    endcase
    for (int i = 0; i < 8; i++) begin
      r[i] = big ? m[7 - i] : m[i];
    end
    return r;
  endfunction : lanes_of

  function automatic logic misaligned(input sz_e s, input logic [2:0] a);
    case (s)
      SZ_HALF: return a[0];
      SZ_WORD: return |a[1:0];
      SZ_DBL:  return |a;
      default: return 1'b0;
    endcase
  endfunction : misaligned

  function automatic logic is_cti(input fields_s f);
    return (f.op >= OP_J && f.op <= OP_BGTZ) || (f.op[5:3] == OPG_LIKELY && f.op[2]) ||
           (f.op == OP_REGIMM && f.tgt[3:2] == 2'h0) ||
           (f.op == OP_SPECIAL && (f.func == FN_JR || f.func == FN_JALR));
  endfunction : is_cti

  function automatic logic is_likely(input fields_s f);
    return (f.op[5:3] == OPG_LIKELY && f.op[2]) || (f.op == OP_REGIMM && f.tgt[1]);
  endfunction : is_likely

  function automatic logic cond_of(input fields_s f, input logic [31:0] a, input logic [31:0] b);
    case (f.op[1:0])
      2'h0:    return a == b;
      2'h1:    return a != b;
      2'h2:    return $signed(a) <= 0;
      default: return $signed(a) > 0;
    endcase
  endfunction : cond_of

  function automatic logic taken_of(input fields_s f, input logic [31:0] a,
                                    input logic [31:0] b);
    if (f.op == OP_REGIMM) return f.tgt[0] ? !a[31] : a[31];
    if (f.op == OP_J || f.op == OP_JAL || f.op == OP_SPECIAL) return 1'b1;
    return cond_of(f, a, b);
  endfunction : taken_of

  logic [1:0]  ctrl_q;
  logic [31:0] insn_q, pc_q, srcv_q, tgtv_q;
  ahb_req_s    req_q;
  st_e         st_q, st_d;
  logic [3:0]  wait_q, mul_q;
  logic        ld_valid_q;
  logic [4:0]  ld_dst_q;
  logic        slot_q, likely_q, taken_q, null_q;
  logic        hreadyout_q, stall_q, err_q;
  logic [31:0] hrdata_q;

  // new instruction on the write data bus, checked for hazards before it is taken
  wire fields_s    nf        = unpack(i_hwdata);
  wire logic       accept    = i_hsel && i_htrans[1] && i_hready;
  wire logic       insn_wr   = accept && i_hwrite && (i_haddr[5:0] == OFS_INSN);
  wire logic       reads_tgt = (nf.op == OP_SPECIAL) || (nf.op[5:3] == OPG_STORE) ||
                               (nf.op[5:3] == OPG_STOREX) || (nf.op[5:1] == 5'h02) ||
                               (nf.op[5:1] == 5'h0a);
  wire logic       ld_hit    = ld_valid_q && (ld_dst_q != 5'h00) &&
                               ((nf.src == ld_dst_q) || (reads_tgt && nf.tgt == ld_dst_q));
  wire logic       mf_hit    = (nf.op == OP_SPECIAL) && (mul_q != 4'h0) &&
                               (nf.func == FN_RD_TOP || nf.func == FN_RD_BOT);
  wire logic [3:0] hold_cnt  = mf_hit ? mul_q : (ld_hit ? LOAD_STALL_CYC : 4'h0);
  wire logic       nf_mul    = (nf.op == OP_SPECIAL && nf.func[5:3] == FNG_MULDIV) ||
                               (nf.op == OP_SPECIAL2 && nf.func[5:3] == 3'h0 && !nf.func[1]);
  wire logic       commit    = (st_q == ST_EVAL && hold_cnt == 4'h0) ||
                               (st_q == ST_HOLD && wait_q == 4'h1);
  wire logic       reg_wr    = req_q.valid && req_q.write && hreadyout_q;

  // decode of the committed instruction
  wire fields_s     cf        = unpack(insn_q);
  wire fmt_e        fmt       = fmt_of(cf.op);
  wire logic        cur_trap  = (cf.op == OP_SPECIAL) && ((cf.func[5:3] == FNG_TRAP) ||
                               cf.func == FN_SYSCALL || cf.func == FN_BREAK);
  wire logic        big       = ctrl_q[CTRL_BIG_BIT];
  wire logic [31:0] sext_imm  = {{16{cf.imm[15]}}, cf.imm};
  wire logic        zext      = (cf.op >= OP_ANDI) && (cf.op <= OP_XORI);
  wire logic [31:0] opnd      = (fmt == FMT_REG) ? tgtv_q :
                                (zext ? {16'h0000, cf.imm} : sext_imm);
  wire logic        mem       = is_mem(cf);
  wire sz_e         dsz       = size_of(cf);
  wire logic [31:0] eaddr     = is_indexed(cf) ? 32'(srcv_q + tgtv_q)
                                               : 32'(srcv_q + sext_imm);
  wire logic [7:0]  dlanes    = mem ? lanes_of(dsz, eaddr[2:0], big) : 8'h00;
  wire logic        derr      = mem && misaligned(dsz, eaddr[2:0]);
  // compressed code fetches halfwords, 32-bit code fetches aligned words
  wire sz_e         fsz       = ctrl_q[CTRL_COMP_BIT] ? SZ_HALF : SZ_WORD;
  wire logic [7:0]  flanes    = lanes_of(fsz, pc_q[2:0], big);
  wire logic        ferr      = misaligned(fsz, pc_q[2:0]);
  wire logic [31:0] slot_pc   = 32'(pc_q + 32'h4);
  wire logic        is_jr     = (cf.op == OP_SPECIAL) && (cf.func == FN_JR || cf.func == FN_JALR);
  wire logic [31:0] br_off    = {{14{cf.imm[15]}}, cf.imm, 2'b00};
  wire logic [31:0] target    = (fmt == FMT_JUMP) ? {slot_pc[31:28], cf.jidx, 2'b00} :
                                is_jr ? srcv_q :
                                32'(slot_pc + br_off);
  wire logic [31:0] fields_w  = {3'h0, cur_trap, fmt, cf.func, cf.shift, cf.dst, cf.tgt, cf.src};
  wire logic [31:0] status_w  = {flanes, 4'h0, mul_q, dlanes, 2'h0, mem, taken_q, slot_q,
                                 null_q, ferr, derr};
  logic [31:0] rd_mux;

  always_comb begin
    case (i_haddr[5:0])
      OFS_CTRL:   rd_mux = {30'h0, ctrl_q};
      OFS_INSN:   rd_mux = insn_q;
      OFS_PC:     rd_mux = pc_q;
      OFS_SRCV:   rd_mux = srcv_q;
      OFS_TGTV:   rd_mux = tgtv_q;
      OFS_FIELDS: rd_mux = fields_w;
      OFS_OPND:   rd_mux = opnd;
      OFS_TARGET: rd_mux = target;
      OFS_EADDR:  rd_mux = eaddr;
      OFS_STATUS: rd_mux = status_w;
      default:    rd_mux = WORD_RST;
    endcase
  end

  always_comb begin
    case (st_q)
      ST_IDLE: st_d = insn_wr ? ST_EVAL : ST_IDLE;
      ST_EVAL: st_d = (hold_cnt != 4'h0) ? ST_HOLD : ST_IDLE;
      ST_HOLD: st_d = (wait_q == 4'h1) ? ST_IDLE : ST_HOLD;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      req_q       <= '0;
      hreadyout_q <= 1'b1;
      hrdata_q    <= WORD_RST;
    end else begin
      if (hreadyout_q) begin
        req_q <= accept ? ahb_req_s'{valid: 1'b1, write: i_hwrite, addr: i_haddr[5:0]} : '0;
      end
      // instruction writes hold the data phase while interlocks run
      hreadyout_q <= insn_wr ? 1'b0 : (commit ? 1'b1 : hreadyout_q);
      if (accept && !i_hwrite) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= CTRL_RST;
      pc_q   <= WORD_RST;
      srcv_q <= WORD_RST;
      tgtv_q <= WORD_RST;
    end else if (reg_wr) begin
      if (req_q.addr == OFS_CTRL) ctrl_q <= i_hwdata[1:0];
      if (req_q.addr == OFS_PC) pc_q <= i_hwdata;
      if (req_q.addr == OFS_SRCV) srcv_q <= i_hwdata;
      if (req_q.addr == OFS_TGTV) tgtv_q <= i_hwdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q    <= ST_IDLE;
      wait_q  <= 4'h0;
      stall_q <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      wait_q  <= (st_q == ST_EVAL) ? hold_cnt : (wait_q != 4'h0 ? wait_q - 4'h1 : 4'h0);
      stall_q <= (st_d == ST_HOLD);
      err_q   <= derr || ferr;
    end
  end

  // pipeline history: last load, multiplier busy time, delay-slot bookkeeping
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      insn_q     <= WORD_RST;
      ld_valid_q <= 1'b0;
      ld_dst_q   <= 5'h00;
      mul_q      <= 4'h0;
      slot_q     <= 1'b0;
      likely_q   <= 1'b0;
      taken_q    <= 1'b0;
      null_q     <= 1'b0;
    end else begin
      mul_q <= (commit && nf_mul) ? MUL_LAT_CYC : (mul_q != 4'h0 ? mul_q - 4'h1 : 4'h0);
      if (commit) begin
        insn_q     <= i_hwdata;
        ld_valid_q <= is_load(nf);
        ld_dst_q   <= nf.tgt;
        slot_q     <= is_cti(nf);
        likely_q   <= is_likely(nf);
        taken_q    <= taken_of(nf, srcv_q, tgtv_q);
        null_q     <= slot_q && likely_q && !taken_q;
      end
    end
  end

  assign o_hreadyout = hreadyout_q;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = hrdata_q;
  assign o_stall     = stall_q;
  assign o_addr_err  = err_q;

  property p_fetch_err;
    @(posedge i_clk) disable iff (i_rst)
      (ctrl_q[CTRL_COMP_BIT] ? pc_q[0] : |pc_q[1:0]) |=> o_addr_err;
  endproperty
  a_fetch_err: assert property (p_fetch_err)
    else $error("misaligned fetch not flagged");

  property p_load_stall;
    @(posedge i_clk) disable iff (i_rst)
      (st_q == ST_EVAL && ld_hit && !mf_hit) |=> (o_stall && !o_hreadyout) ##1 o_hreadyout;
  endproperty
  a_load_stall: assert property (p_load_stall)
    else $error("load interlock cycle wrong");

  property p_product_stall;
    @(posedge i_clk) disable iff (i_rst)
      (st_q == ST_EVAL && mf_hit) |=> (o_stall && !o_hreadyout) ##[0:3]
                                      (mul_q == 4'h0 && !o_hreadyout);
  endproperty
  a_product_stall: assert property (p_product_stall)
    else $error("product read not held");

  property p_ready_returns;
    @(posedge i_clk) disable iff (i_rst)
      !o_hreadyout |-> ##[1:8] o_hreadyout;
  endproperty
  a_ready_returns: assert property (p_ready_returns)
    else $error("data phase never ends");

  property p_jump_target;
    @(posedge i_clk) disable iff (i_rst)
      (cf.op == OP_J) |-> (target[27:0] == {insn_q[25:0], 2'b00}) &&
                          (target[31:28] == slot_pc[31:28]);
  endproperty
  a_jump_target: assert property (p_jump_target)
    else $error("jump target wrong");

  property p_branch_target;
    @(posedge i_clk) disable iff (i_rst)
      (cf.op == OP_BEQ) |-> ($signed(target - pc_q - 32'h4) == $signed(sext_imm) * 4);
  endproperty
  a_branch_target: assert property (p_branch_target)
    else $error("branch target wrong");

  property p_nullify;
    @(posedge i_clk) disable iff (i_rst)
      (commit && slot_q && likely_q && !taken_q) |=> null_q [*2];
  endproperty
  a_nullify: assert property (p_nullify)
    else $error("likely delay slot not nullified");

  property p_big_byte;
    @(posedge i_clk) disable iff (i_rst)
      (mem && big && dsz == SZ_BYTE) |-> (dlanes == (8'h80 >> eaddr[2:0]));
  endproperty
  a_big_byte: assert property (p_big_byte)
    else $error("big-endian byte lane wrong");

  property p_int_addr;
    @(posedge i_clk) disable iff (i_rst)
      (mem && cf.op[5:3] == OPG_LOAD) |-> (32'(eaddr - srcv_q) == sext_imm);
  endproperty
  a_int_addr: assert property (p_int_addr)
    else $error("integer effective address wrong");

  property p_dbl_align;
    @(posedge i_clk) disable iff (i_rst)
      (mem && dsz == SZ_DBL && eaddr[2:0] != 3'h0) |=> o_addr_err;
  endproperty
  a_dbl_align: assert property (p_dbl_align)
    else $error("doubleword misalignment missed");

endmodule : insn_decode_top

// *** testbench/insn_store_model.sv ***
// instruction store model on the fetch side of the decoder
`timescale 1ns/1ps
module insn_store_model
(
  input  wire logic        i_clk,
  input  wire logic        i_we,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  output logic [31:0]      o_word
);
  logic [31:0] mem_q [16];
  always_ff @(posedge i_clk) begin
    if (i_we) mem_q[i_addr[5:2]] <= i_wdata;
  end
  // whole aligned words only: the low two address bits never select
  assign o_word = mem_q[i_addr[5:2]];
endmodule : insn_store_model

// *** testbench/tb_insn_decode_top.sv ***
// self-checking bench for the instruction format decoder
`timescale 1ns/1ps
module tb_insn_decode_top
  import decode_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic        mem_we = 1'b0;
  logic [31:0] mem_addr = 32'h0;
  logic [31:0] mem_wdata = 32'h0;
  logic [31:0] mem_word, hrdata, rd, pc, pc4, a, b, w, x;
  logic        hreadyout, hresp, stall, addr_err, sst;
  logic [5:0]  ops [4];
  int          failures = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          n;
  integer      seed = 32'hd3c377bd;

  insn_decode_top dut_u (
    .i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
    .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata), .o_stall(stall),
    .o_addr_err(addr_err)
  );
  insn_store_model mem_u (
    .i_clk(clk), .i_we(mem_we), .i_addr(mem_addr), .i_wdata(mem_wdata), .o_word(mem_word)
  );

  initial forever #10 clk = ~clk;

  task wrap_up;
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end

  task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // negedge look sees what the next rising edge samples, free of races
  task xfer(input logic wr, input logic [5:0] ad, input logic [31:0] d);
    logic done;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {26'h0, ad};
    hwrite <= wr;
    done = 1'b0;
    while (!done) begin
      @(negedge clk);
      done = (hreadyout === 1'b1);
      @(posedge clk);
    end
    htrans <= 2'h0;
    hwdata <= d;
    done = 1'b0;
    n = 0;
    sst = 1'b0;
    while (!done) begin
      @(negedge clk);
      done = (hreadyout === 1'b1);
      sst = sst | (stall === 1'b1);
      rd = hrdata;
      if (!done) n++;
      @(posedge clk);
    end
  endtask : xfer

  task wr(input logic [5:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d);
  endtask : wr

  task rdc(input string nm, input logic [5:0] ad, input logic [31:0] e,
           input logic [31:0] m = 32'hffffffff);
    xfer(1'b0, ad, 32'h0);
    check(nm, rd & m, e);
  endtask : rdc

  task issue(input logic [31:0] p, input logic [31:0] s, input logic [31:0] t,
             input logic [31:0] i);
    wr(OFS_PC, p);
    wr(OFS_SRCV, s);
    wr(OFS_TGTV, t);
    wr(OFS_INSN, i);
  endtask : issue

  // error pin is a flop, so look at it mid-cycle and hand back on a rising edge
  task err_pin(input logic e);
    @(negedge clk);
    check("addr_err_pin", addr_err, e);
    @(posedge clk);
  endtask : err_pin

  function automatic logic [31:0] sx(input logic [15:0] i);
    return {{16{i[15]}}, i};
  endfunction : sx

  // fields outside a layout are left open, so they are masked away
  function automatic logic [31:0] fld_mask(input logic [5:0] op);
    if (op == OP_SPECIAL) return 32'h0fffffff;
    if (op == OP_J) return 32'h0c000000;
    return 32'h0c0003ff;
  endfunction : fld_mask

  function automatic logic [31:0] fld_exp(input logic [31:0] i);
    logic [1:0] f;
    f = (i[31:26] == OP_SPECIAL) ? 2'h2 : (i[31:27] == 5'h01) ? 2'h1 : 2'h0;
    return {4'h0, f, i[5:0], i[10:6], i[15:11], i[20:16], i[25:21]} & fld_mask(i[31:26]);
  endfunction : fld_exp

  initial begin
    ops[0] = OP_SPECIAL;
    ops[1] = OP_ANDI;
    ops[2] = OP_J;
    ops[3] = {OPG_LOAD, 3'h3};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc("ctrl_rst", OFS_CTRL, 32'h0);
    rdc("insn_rst", OFS_INSN, 32'h0);
    rdc("unmapped", 6'h3c, 32'h0);
    for (int i = 0; i < 12; i++) begin
      pc = $random(seed) & 32'hfffffffc;
      pc4 = pc + 32'h4;
      a = $random(seed);
      b = $random(seed);
      w = $random(seed);
      w[31:26] = ops[i % 4];
      // bit 3 cleared: no register jump or multiply in a delay slot
      w[5:3] = w[5:3] & 3'h6;
      mem_we <= 1'b1;
      mem_addr <= pc;
      mem_wdata <= w;
      @(posedge clk);
      mem_we <= 1'b0;
      @(negedge clk);
      x = mem_word;
      @(posedge clk);
      issue(pc, a, b, x);
      rdc("fields", OFS_FIELDS, fld_exp(w), fld_mask(w[31:26]));
      case (i % 4)
        0: rdc("opnd_reg", OFS_OPND, b);
        1: rdc("opnd_imm", OFS_OPND, {16'h0, w[15:0]});
        2: rdc("jump_tgt", OFS_TARGET, {pc4[31:28], w[25:0], 2'h0});
        default: rdc("eaddr", OFS_EADDR, a + sx(w[15:0]));
      endcase
    end
    pc = 32'h00001000;
    issue(pc, a, b, {OP_SPECIAL, 5'h3, 15'h0, FN_JR});
    rdc("jr_tgt", OFS_TARGET, a);
    rdc("jr_slot", OFS_STATUS, 32'h8, 32'h8);
    issue(pc, a, b, {OP_ANDI, 26'h1});
    rdc("slot_plain", OFS_STATUS, 32'h0, 32'h1c);
    issue(pc, a, a, {OP_BEQ, 5'h1, 5'h2, 16'hfff0});
    rdc("br_tgt", OFS_TARGET, pc + 32'h4 + (sx(16'hfff0) << 2));
    rdc("br_taken", OFS_STATUS, 32'h18, 32'h18);
    issue(pc, a, b, {OP_ANDI, 26'h1});
    for (int t = 0; t < 2; t++) begin
      issue(pc, a, t ? a : ~a, {OPG_LIKELY, 3'h4, 5'h1, 5'h2, 16'h4});
      issue(pc + 32'h4, a, b, {OP_ANDI, 26'h1});
      rdc("nullify", OFS_STATUS, t ? 32'h0 : 32'h4, 32'h4);
    end
    issue(pc, a, b, {OPG_LOAD, 3'h3, 5'h1, 5'h5, 16'h10});
    issue(pc, a, b, {OP_ANDI, 5'h5, 5'h6, 16'h1});
    check("load_use_wait", n, 2);
    check("load_use_stall", sst, 1'b1);
    issue(pc, a, b, {OP_ANDI, 5'h5, 5'h6, 16'h1});
    check("plain_wait", n, 1);
    issue(pc, a, b, {OP_SPECIAL, 5'h1, 5'h2, 10'h0, 6'h18});
    wr(OFS_INSN, {OP_SPECIAL, 10'h0, 5'h4, 5'h0, FN_RD_TOP});
    check("product_wait", n > 1, 1'b1);
    repeat (8) @(posedge clk);
    wr(OFS_INSN, {OP_SPECIAL, 10'h0, 5'h4, 5'h0, FN_RD_BOT});
    check("product_ready", n, 1);
    for (int e = 0; e < 2; e++) begin
      wr(OFS_CTRL, e);
      for (int k = 0; k < 8; k++) begin
        issue(pc, k, 32'h0, {OPG_LOAD, 3'h0, 5'h1, 21'h0});
        rdc("byte_lane", OFS_STATUS, {16'h0, (e ? 8'h80 >> k : 8'h01 << k), 8'h0},
            32'hff00);
        issue(pc, k, 32'h0, {OPG_LOAD, 3'h1, 5'h1, 21'h0});
        rdc("half_align", OFS_STATUS, k & 1, 32'h1);
        err_pin(k[0]);
      end
    end
    for (int m = 0; m < 2; m++) begin
      wr(OFS_CTRL, m * 2);
      issue(32'h2, a, b, {OP_ANDI, 26'h1});
      rdc("fetch", OFS_STATUS, m ? 32'h0c000000 : 32'h2,
          m ? 32'hff000002 : 32'h2);
      err_pin(m == 0);
    end
    issue(pc, a, b, {OP_SPECIAL, 5'h1, 5'h2, 10'h0, 6'h34});
    rdc("trap_form", OFS_FIELDS, 32'h18000000, 32'h1c000000);
    issue(pc, a, b, {OP_COP1X, 5'h1, 5'h2, 16'h0});
    rdc("indexed", OFS_EADDR, a + b);
    issue(pc, 32'h4, 32'h0, {OP_COP1X, 5'h1, 5'h2, 10'h0, 6'h01});
    rdc("dbl_align", OFS_STATUS, 32'h21, 32'h21);
    err_pin(1'b1);
    check("hresp", hresp, 1'b0);
    wrap_up();
  end
endmodule : tb_insn_decode_top
